// *** rtl/imad_addr_decode.sv ***
// combinational decode of one address onto the internal memory blocks
`timescale 1ns/1ns
`default_nettype none
`include "imad_defines.svh"
module imad_addr_decode (
	imad_dec_if.dec d
);
	localparam int NENT = `IMAD_NENT;
	localparam logic [`IMAD_ADDR_W-1:0] ENT_LO [NENT] = '{
		`IMAD_LW_SRAM0_LO, `IMAD_LW_SRAM1_LO,
		`IMAD_NW_SRAM0_LO, `IMAD_NW_ROM0_LO,
		`IMAD_NW_SRAM1_LO, `IMAD_NW_ROM1_LO,
		`IMAD_IW_ROM0_LO, `IMAD_IW_ROM1_LO,
		`IMAD_SW_SRAM0_LO, `IMAD_SW_ROM0_LO,
		`IMAD_SW_SRAM1_LO, `IMAD_SW_ROM1_LO};
	localparam logic [`IMAD_ADDR_W-1:0] ENT_HI [NENT] = '{
		`IMAD_LW_SRAM0_HI, `IMAD_LW_SRAM1_HI,
		`IMAD_NW_SRAM0_HI, `IMAD_NW_ROM0_HI,
		`IMAD_NW_SRAM1_HI, `IMAD_NW_ROM1_HI,
		`IMAD_IW_ROM0_HI, `IMAD_IW_ROM1_HI,
		`IMAD_SW_SRAM0_HI, `IMAD_SW_ROM0_HI,
		`IMAD_SW_SRAM1_HI, `IMAD_SW_ROM1_HI};
	localparam logic [1:0] ENT_BLK [NENT] = '{
		`IMAD_BLK_SRAM0, `IMAD_BLK_SRAM1,
		`IMAD_BLK_SRAM0, `IMAD_BLK_ROM0, `IMAD_BLK_SRAM1, `IMAD_BLK_ROM1,
		`IMAD_BLK_ROM0, `IMAD_BLK_ROM1,
		`IMAD_BLK_SRAM0, `IMAD_BLK_ROM0, `IMAD_BLK_SRAM1, `IMAD_BLK_ROM1};
	localparam imad_pkg::imad_width_e ENT_W [NENT] = '{
		imad_pkg::IMAD_W_LONG, imad_pkg::IMAD_W_LONG,
		imad_pkg::IMAD_W_NORMAL, imad_pkg::IMAD_W_NORMAL,
		imad_pkg::IMAD_W_NORMAL, imad_pkg::IMAD_W_NORMAL,
		imad_pkg::IMAD_W_INSTR, imad_pkg::IMAD_W_INSTR,
		imad_pkg::IMAD_W_SHORT, imad_pkg::IMAD_W_SHORT,
		imad_pkg::IMAD_W_SHORT, imad_pkg::IMAD_W_SHORT};

	logic [NENT-1:0]        ent_hit;
	logic [`IMAD_ADDR_W-1:0] ent_off [NENT];
	logic                    found;

	genvar k;
	for (k = 0; k < NENT; k++) begin : g_ent
		// instruction windows sit in holes; only 48-bit fetches see them
		assign ent_hit[k] = (d.addr >= ENT_LO[k]) && (d.addr <= ENT_HI[k]) &&
			(d.is48 || (ENT_W[k] != imad_pkg::IMAD_W_INSTR));
		assign ent_off[k] = d.addr - ENT_LO[k];
	end

	assign d.hit_iop = (d.addr <= `IMAD_IOP_HI);
	assign d.hit_ext = (d.addr >= `IMAD_EXT_BASE);

	always_comb begin
		found     = 1'b0;
		d.hit_blk = '0;
		d.offset  = d.addr[`IMAD_OFF_W-1:0];
		d.width   = imad_pkg::IMAD_W_NORMAL;
		for (int i = 0; i < NENT; i++) begin
			if (ent_hit[i] && !found) begin
				found                 = 1'b1;
				d.hit_blk[ENT_BLK[i]] = 1'b1;
				d.offset              = ent_off[i][`IMAD_OFF_W-1:0];
				d.width               = ENT_W[i];
			end
		end
		// holes between blocks fall through to here
		d.reserved = !found && !d.hit_iop && !d.hit_ext;
	end
endmodule
`default_nettype wire

// *** rtl/imad_arb2.sv ***
// fixed-priority grant between two requests for one target port
`timescale 1ns/1ns
`default_nettype none
module imad_arb2 (
	input  wire logic req_hi,
	input  wire logic req_lo,
	output logic      gnt_hi,
	output logic      gnt_lo
);
	assign gnt_hi = req_hi;
	assign gnt_lo = req_lo && !req_hi;
endmodule
`default_nettype wire

// *** rtl/imad_dec_if.sv ***
// decode request and result between requester logic and one address decoder
`timescale 1ns/1ns
`default_nettype none
`include "imad_defines.svh"
interface imad_dec_if;
	logic [`IMAD_ADDR_W-1:0] addr;
	logic                    is48;
	logic [`IMAD_NBLK-1:0]   hit_blk;
	logic                    hit_iop;
	logic                    hit_ext;
	logic                    reserved;
	logic [`IMAD_OFF_W-1:0]  offset;
	imad_pkg::imad_width_e   width;
	modport req (output addr, output is48, input hit_blk, input hit_iop,
		input hit_ext, input reserved, input offset, input width);
	modport dec (input addr, input is48, output hit_blk, output hit_iop,
		output hit_ext, output reserved, output offset, output width);
endinterface
`default_nettype wire

// *** rtl/imad_decoder.sv ***
// internal memory address decoder with per-block core and i/o ports
// Functional notes
// - low 256K words go to io registers
// - normal view: first sram block range
// - normal view: first rom block range
// - normal view: second sram block range
// - normal view: second rom block range
// - normal view gaps select no block, except the two rom windows seen by 48-bit fetches
// - short view: first sram block range
// - short view: first rom block range
// - short view: second sram block range
// - short view: second rom block range
// - short view gaps are reserved
// - long view: first sram block range
// - long view: second sram block range
// - 48-bit fetch: first rom window
// - 48-bit fetch: second rom window
// - core never reaches external memory; dma does
// - core and dma access a block together
`timescale 1ns/1ns
`default_nettype none
`include "imad_defines.svh"
module imad_decoder (
	input  wire logic                                 ref_clk,
	input  wire logic                                 rst,
	// ------------------------------------------------------------
	// requesters
	// ------------------------------------------------------------
	input  wire logic                                 dm_valid,
	input  wire logic [`IMAD_ADDR_W-1:0]              dm_addr,
	input  wire logic                                 dm_write,
	input  wire logic                                 pm_valid,
	input  wire logic [`IMAD_ADDR_W-1:0]              pm_addr,
	input  wire logic                                 pm_write,
	input  wire logic                                 pm_is48,
	input  wire logic                                 dma_valid,
	input  wire logic [`IMAD_ADDR_W-1:0]              dma_addr,
	input  wire logic                                 dma_write,
	// ------------------------------------------------------------
	// responses
	// ------------------------------------------------------------
	output logic                                      dm_ack,
	output logic                                      dm_err,
	output imad_pkg::imad_err_e                       dm_err_code,
	output logic                                      pm_ack,
	output logic                                      pm_stall,
	output logic                                      pm_err,
	output imad_pkg::imad_err_e                       pm_err_code,
	output logic                                      dma_ack,
	output logic                                      dma_stall,
	output logic                                      dma_err,
	output imad_pkg::imad_err_e                       dma_err_code,
	// ------------------------------------------------------------
	// memory block ports
	// ------------------------------------------------------------
	output logic [`IMAD_NBLK-1:0]                     blk_core_en,
	output logic [`IMAD_NBLK-1:0]                     blk_core_write,
	output logic [`IMAD_NBLK-1:0][`IMAD_OFF_W-1:0]    blk_core_off,
	output logic [`IMAD_NBLK-1:0][1:0]                blk_core_width,
	output logic [`IMAD_NBLK-1:0]                     blk_io_en,
	output logic [`IMAD_NBLK-1:0]                     blk_io_write,
	output logic [`IMAD_NBLK-1:0][`IMAD_OFF_W-1:0]    blk_io_off,
	output logic [`IMAD_NBLK-1:0][1:0]                blk_io_width,
	// ------------------------------------------------------------
	// io register space and external memory
	// ------------------------------------------------------------
	output logic                                      iop_en,
	output logic                                      iop_write,
	output logic [`IMAD_OFF_W-1:0]                    iop_off,
	output logic                                      iop_from_dma,
	output logic                                      ext_en,
	output logic                                      ext_write,
	output logic [`IMAD_ADDR_W-1:0]                   ext_addr
);
	// ------------------------------------------------------------
	// decoders, one per requester
	// ------------------------------------------------------------
	imad_dec_if dm_if ();
	imad_dec_if pm_if ();
	imad_dec_if dma_if ();

	assign dm_if.addr  = dm_addr;
	assign dm_if.is48  = 1'b0;
	assign pm_if.addr  = pm_addr;
	assign pm_if.is48  = pm_is48;
	assign dma_if.addr = dma_addr;
	assign dma_if.is48 = 1'b0;

	imad_addr_decode u_dm_dec (
		.d (dm_if)
	);
	imad_addr_decode u_pm_dec (
		.d (pm_if)
	);
	imad_addr_decode u_dma_dec (
		.d (dma_if)
	);

	// ------------------------------------------------------------
	// request qualification
	// ------------------------------------------------------------
	// a write into mask rom has no effect on the array, so it is
	// refused rather than silently dropped
	function automatic imad_pkg::imad_err_e err_of(
		input logic                  reserved,
		input logic                  ext_refused,
		input logic                  write,
		input logic [`IMAD_NBLK-1:0] hit_blk
	);
		imad_pkg::imad_err_e e;
		e = imad_pkg::IMAD_E_NONE;
		if (reserved)
			e = imad_pkg::IMAD_E_RESERVED;
		else if (ext_refused)
			e = imad_pkg::IMAD_E_EXTERNAL;
		else if (write && ((hit_blk & `IMAD_ROM_MASK) != '0))
			e = imad_pkg::IMAD_E_ROMWRITE;
		return e;
	endfunction

	imad_pkg::imad_err_e next_dm_err_code;
	imad_pkg::imad_err_e next_pm_err_code;
	imad_pkg::imad_err_e next_dma_err_code;
	logic                dm_req;
	logic                pm_req;
	logic                dma_req;

	// core buses are refused external space, dma is not
	assign next_dm_err_code  = err_of(dm_if.reserved, dm_if.hit_ext,
		dm_write, dm_if.hit_blk);
	assign next_pm_err_code  = err_of(pm_if.reserved, pm_if.hit_ext,
		pm_write, pm_if.hit_blk);
	assign next_dma_err_code = err_of(dma_if.reserved, 1'b0,
		dma_write, dma_if.hit_blk);

	assign dm_req  = dm_valid && (next_dm_err_code == imad_pkg::IMAD_E_NONE);
	assign pm_req  = pm_valid && (next_pm_err_code == imad_pkg::IMAD_E_NONE);
	assign dma_req = dma_valid && (next_dma_err_code == imad_pkg::IMAD_E_NONE);

	// ------------------------------------------------------------
	// per-block ports
	// ------------------------------------------------------------
	logic [`IMAD_NBLK-1:0] blk_gnt_dm;
	logic [`IMAD_NBLK-1:0] blk_gnt_pm;

	// each block has its own core port and its own i/o port, so a dma
	// block access never waits for the core; only dm and pm contend
	genvar b;
	for (b = 0; b < `IMAD_NBLK; b++) begin : g_blk
		imad_arb2 u_blk_arb (
			.req_hi (dm_req && dm_if.hit_blk[b]),
			.req_lo (pm_req && pm_if.hit_blk[b]),
			.gnt_hi (blk_gnt_dm[b]),
			.gnt_lo (blk_gnt_pm[b])
		);

		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				blk_core_en[b]    <= 1'b0;
				blk_core_write[b] <= 1'b0;
				blk_core_off[b]   <= '0;
				blk_core_width[b] <= imad_pkg::IMAD_W_NORMAL;
			end else begin
				blk_core_en[b] <= blk_gnt_dm[b] || blk_gnt_pm[b];
				if (blk_gnt_dm[b]) begin
					blk_core_write[b] <= dm_write;
					blk_core_off[b]   <= dm_if.offset;
					blk_core_width[b] <= dm_if.width;
				end else if (blk_gnt_pm[b]) begin
					blk_core_write[b] <= pm_write;
					blk_core_off[b]   <= pm_if.offset;
					blk_core_width[b] <= pm_if.width;
				end
			end
		end

		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				blk_io_en[b]    <= 1'b0;
				blk_io_write[b] <= 1'b0;
				blk_io_off[b]   <= '0;
				blk_io_width[b] <= imad_pkg::IMAD_W_NORMAL;
			end else begin
				blk_io_en[b] <= dma_req && dma_if.hit_blk[b];
				if (dma_req && dma_if.hit_blk[b]) begin
					blk_io_write[b] <= dma_write;
					blk_io_off[b]   <= dma_if.offset;
					blk_io_width[b] <= dma_if.width;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// io register space
	// ------------------------------------------------------------
	logic iop_gnt_dm;
	logic iop_gnt_pm;
	logic iop_gnt_dma;

	// register space has a single port; the core wins over dma
	imad_arb2 u_iop_arb (
		.req_hi (dm_req && dm_if.hit_iop),
		.req_lo (pm_req && pm_if.hit_iop),
		.gnt_hi (iop_gnt_dm),
		.gnt_lo (iop_gnt_pm)
	);
	assign iop_gnt_dma = dma_req && dma_if.hit_iop && !iop_gnt_dm && !iop_gnt_pm;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			iop_en       <= 1'b0;
			iop_write    <= 1'b0;
			iop_off      <= '0;
			iop_from_dma <= 1'b0;
		end else begin
			iop_en       <= iop_gnt_dm || iop_gnt_pm || iop_gnt_dma;
			iop_from_dma <= iop_gnt_dma;
			if (iop_gnt_dm) begin
				iop_write <= dm_write;
				iop_off   <= dm_if.offset;
			end else if (iop_gnt_pm) begin
				iop_write <= pm_write;
				iop_off   <= pm_if.offset;
			end else if (iop_gnt_dma) begin
				iop_write <= dma_write;
				iop_off   <= dma_if.offset;
			end
		end
	end

	// ------------------------------------------------------------
	// external memory, reached by dma only
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ext_en    <= 1'b0;
			ext_write <= 1'b0;
			ext_addr  <= '0;
		end else begin
			ext_en <= dma_req && dma_if.hit_ext;
			if (dma_req && dma_if.hit_ext) begin
				ext_write <= dma_write;
				ext_addr  <= dma_addr;
			end
		end
	end

	// ------------------------------------------------------------
	// responses
	// ------------------------------------------------------------
	logic pm_granted;
	logic dma_granted;

	assign pm_granted  = (blk_gnt_pm != '0) || iop_gnt_pm;
	assign dma_granted = (dma_if.hit_blk != '0) || dma_if.hit_ext || iop_gnt_dma;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dm_ack      <= 1'b0;
			dm_err      <= 1'b0;
			dm_err_code <= imad_pkg::IMAD_E_NONE;
		end else begin
			// dm holds top priority everywhere, so a clean request is taken
			dm_ack      <= dm_req;
			dm_err      <= dm_valid && !dm_req;
			dm_err_code <= dm_valid ? next_dm_err_code : imad_pkg::IMAD_E_NONE;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pm_ack      <= 1'b0;
			pm_stall    <= 1'b0;
			pm_err      <= 1'b0;
			pm_err_code <= imad_pkg::IMAD_E_NONE;
		end else begin
			pm_ack      <= pm_req && pm_granted;
			pm_stall    <= pm_req && !pm_granted;
			pm_err      <= pm_valid && !pm_req;
			pm_err_code <= pm_valid ? next_pm_err_code : imad_pkg::IMAD_E_NONE;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dma_ack      <= 1'b0;
			dma_stall    <= 1'b0;
			dma_err      <= 1'b0;
			dma_err_code <= imad_pkg::IMAD_E_NONE;
		end else begin
			dma_ack      <= dma_req && dma_granted;
			dma_stall    <= dma_req && !dma_granted;
			dma_err      <= dma_valid && !dma_req;
			dma_err_code <= dma_valid ? next_dma_err_code : imad_pkg::IMAD_E_NONE;
		end
	end
endmodule
`default_nettype wire

// *** rtl/imad_defines.svh ***
// address map and width constants for the internal memory address decoder
`ifndef IMAD_DEFINES_SVH
`define IMAD_DEFINES_SVH

`define IMAD_ADDR_W       32
`define IMAD_OFF_W        18
`define IMAD_NBLK         4
`define IMAD_NENT         12

`define IMAD_BLK_SRAM0    2'h0
`define IMAD_BLK_ROM0     2'h1
`define IMAD_BLK_SRAM1    2'h2
`define IMAD_BLK_ROM1     2'h3
`define IMAD_ROM_MASK     4'hA

`define IMAD_IOP_LO       32'h0000_0000
`define IMAD_IOP_HI       32'h0003_FFFF

`define IMAD_LW_SRAM0_LO  32'h0004_0000
`define IMAD_LW_SRAM0_HI  32'h0004_1FFF
`define IMAD_LW_SRAM1_LO  32'h0006_0000
`define IMAD_LW_SRAM1_HI  32'h0006_1FFF

`define IMAD_NW_SRAM0_LO  32'h0008_0000
`define IMAD_NW_SRAM0_HI  32'h0008_3FFF
`define IMAD_NW_ROM0_LO   32'h000B_0000
`define IMAD_NW_ROM0_HI   32'h000B_BFFF
`define IMAD_NW_SRAM1_LO  32'h000C_0000
`define IMAD_NW_SRAM1_HI  32'h000C_3FFF
`define IMAD_NW_ROM1_LO   32'h000F_0000
`define IMAD_NW_ROM1_HI   32'h000F_BFFF

`define IMAD_IW_ROM0_LO   32'h000A_0000
`define IMAD_IW_ROM0_HI   32'h000A_AAAA
`define IMAD_IW_ROM1_LO   32'h000E_0000
`define IMAD_IW_ROM1_HI   32'h000E_AAAA

`define IMAD_SW_SRAM0_LO  32'h0010_0000
`define IMAD_SW_SRAM0_HI  32'h0010_7FFF
`define IMAD_SW_ROM0_LO   32'h0016_0000
`define IMAD_SW_ROM0_HI   32'h0017_7FFF
`define IMAD_SW_SRAM1_LO  32'h0018_0000
`define IMAD_SW_SRAM1_HI  32'h0018_7FFF
`define IMAD_SW_ROM1_LO   32'h001E_0000
`define IMAD_SW_ROM1_HI   32'h001F_7FFF

`define IMAD_EXT_BASE     32'h0020_0000

`endif

// *** rtl/imad_pkg.sv ***
// types shared by the internal memory address decoder
`default_nettype none
package imad_pkg;
	typedef enum logic [1:0] {
		IMAD_W_LONG   = 2'h0,
		IMAD_W_NORMAL = 2'h1,
		IMAD_W_SHORT  = 2'h2,
		IMAD_W_INSTR  = 2'h3
	} imad_width_e;
	typedef enum logic [1:0] {
		IMAD_E_NONE     = 2'h0,
		IMAD_E_RESERVED = 2'h1,
		IMAD_E_EXTERNAL = 2'h2,
		IMAD_E_ROMWRITE = 2'h3
	} imad_err_e;
endpackage
`default_nettype wire

// *** tb/imad_decoder_asserts.sv ***
// concurrent checks on the ports of the internal memory address decoder
`timescale 1ns/1ns
`default_nettype none
`include "imad_defines.svh"
module imad_decoder_asserts (
	input wire logic                                 ref_clk,
	input wire logic                                 rst,
	input wire logic                                 dm_valid,
	input wire logic [`IMAD_ADDR_W-1:0]              dm_addr,
	input wire logic                                 pm_valid,
	input wire logic                                 dma_valid,
	input wire logic [`IMAD_ADDR_W-1:0]              dma_addr,
	input wire logic                                 dm_ack,
	input wire logic                                 dm_err,
	input wire imad_pkg::imad_err_e                  dm_err_code,
	input wire logic                                 pm_ack,
	input wire logic                                 pm_stall,
	input wire logic                                 pm_err,
	input wire logic                                 dma_ack,
	input wire logic                                 dma_stall,
	input wire logic                                 dma_err,
	input wire logic [`IMAD_NBLK-1:0]                blk_core_en,
	input wire logic [`IMAD_NBLK-1:0][`IMAD_OFF_W-1:0] blk_core_off,
	input wire logic [`IMAD_NBLK-1:0][1:0]           blk_core_width,
	input wire logic [`IMAD_NBLK-1:0]                blk_io_en,
	input wire logic [`IMAD_NBLK-1:0][`IMAD_OFF_W-1:0] blk_io_off,
	input wire logic                                 iop_en,
	input wire logic [`IMAD_OFF_W-1:0]               iop_off,
	input wire logic                                 ext_en,
	input wire logic [`IMAD_ADDR_W-1:0]              ext_addr
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	dm_answer_a: assert property (dm_valid |=> $onehot({dm_ack, dm_err}))
		else $error("data bus answer missing or doubled");
	pm_answer_a: assert property (pm_valid |=> $onehot({pm_ack, pm_stall, pm_err}))
		else $error("program bus answer missing or doubled");
	dma_answer_a: assert property (dma_valid |=> $onehot({dma_ack, dma_stall, dma_err}))
		else $error("dma answer missing or doubled");
	iop_route_a: assert property (dm_valid && dm_addr <= `IMAD_IOP_HI
		|=> iop_en && dm_ack && iop_off == $past(dm_addr[17:0])) else $error("io space missed");
	sram0_core_a: assert property (dm_valid && dm_addr inside {[32'h80000:32'h83FFF]}
		|=> blk_core_en[0] && blk_core_off[0] == $past(dm_addr[17:0]) && blk_core_width[0] == 2'h1)
		else $error("core sram0 select wrong");
	sram0_dma_a: assert property (dma_valid && dma_addr inside {[32'h80000:32'h83FFF]}
		|=> blk_io_en[0] && dma_ack && blk_io_off[0] == $past(dma_addr[17:0]))
		else $error("dma sram0 select wrong");
	gap_refused_a: assert property (dm_valid && dm_addr inside {[32'h84000:32'h9FFFF]}
		|=> dm_err && dm_err_code == imad_pkg::IMAD_E_RESERVED) else $error("gap not refused");
	core_ext_a: assert property (dm_valid && dm_addr >= `IMAD_EXT_BASE
		|=> dm_err && dm_err_code == imad_pkg::IMAD_E_EXTERNAL) else $error("core reached ext");
	dma_ext_a: assert property (dma_valid && dma_addr >= `IMAD_EXT_BASE
		|=> ext_en && ext_addr == $past(dma_addr)) else $error("dma ext access lost");
	dual_c: cover property (dm_valid && dma_valid ##1 dm_ack && dma_ack);
	stall_c: cover property (pm_valid ##1 pm_stall);
	ext_c: cover property (dma_valid ##1 ext_en);
endmodule
bind imad_decoder imad_decoder_asserts chk (.ref_clk, .rst, .dm_valid, .dm_addr, .pm_valid,
	.dma_valid, .dma_addr, .dm_ack, .dm_err, .dm_err_code, .pm_ack, .pm_stall, .pm_err,
	.dma_ack, .dma_stall, .dma_err, .blk_core_en, .blk_core_off, .blk_core_width, .blk_io_en,
	.blk_io_off, .iop_en, .iop_off, .ext_en, .ext_addr);
`default_nettype wire

// *** tb/imad_decoder_tb.sv ***
// self-checking bench for the internal memory address decoder
`timescale 1ns/1ns
`default_nettype none
`include "imad_defines.svh"
module imad_decoder_tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic dm_valid, dm_write, pm_valid, pm_write, pm_is48, dma_valid, dma_write;
	logic [`IMAD_ADDR_W-1:0] dm_addr, pm_addr, dma_addr, ext_addr;
	logic dm_ack, dm_err, pm_ack, pm_stall, pm_err, dma_ack, dma_stall, dma_err;
	imad_pkg::imad_err_e dm_err_code, pm_err_code, dma_err_code;
	logic [`IMAD_NBLK-1:0] blk_core_en, blk_core_write, blk_io_en, blk_io_write;
	logic [`IMAD_NBLK-1:0][`IMAD_OFF_W-1:0] blk_core_off, blk_io_off;
	logic [`IMAD_NBLK-1:0][1:0] blk_core_width, blk_io_width;
	logic iop_en, iop_write, iop_from_dma, ext_en, ext_write;
	logic [`IMAD_OFF_W-1:0] iop_off;
	int n_errors = 0;
	int tests_run = 0;
	// range table: long, normal, 48-bit, short views
	localparam logic [31:0] LO [12] = '{32'h40000, 32'h60000, 32'h80000, 32'hB0000,
		32'hC0000, 32'hF0000, 32'hA0000, 32'hE0000, 32'h100000, 32'h160000, 32'h180000, 32'h1E0000};
	localparam logic [31:0] HI [12] = '{32'h41FFF, 32'h61FFF, 32'h83FFF, 32'hBBFFF,
		32'hC3FFF, 32'hFBFFF, 32'hAAAAA, 32'hEAAAA, 32'h107FFF, 32'h177FFF, 32'h187FFF, 32'h1F7FFF};
	localparam int BK [12] = '{0, 2, 0, 1, 2, 3, 1, 3, 0, 1, 2, 3};
	localparam logic [1:0] WD [12] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h3, 2'h3,
		2'h2, 2'h2, 2'h2, 2'h2};
	localparam logic [31:0] GAP [9] = '{32'h42000, 32'h84000, 32'hA0000, 32'hBC000,
		32'hFC000, 32'h108000, 32'h15FFFF, 32'h188000, 32'h1F8000};

	always #20 ref_clk = ~ref_clk;
	imad_req_model m (.dm_valid, .dm_addr, .dm_write, .pm_valid, .pm_addr, .pm_write,
		.pm_is48, .dma_valid, .dma_addr, .dma_write);
	imad_decoder DUT (.ref_clk, .rst, .dm_valid, .dm_addr, .dm_write, .pm_valid, .pm_addr,
		.pm_write, .pm_is48, .dma_valid, .dma_addr, .dma_write, .dm_ack, .dm_err,
		.dm_err_code, .pm_ack, .pm_stall, .pm_err, .pm_err_code, .dma_ack, .dma_stall,
		.dma_err, .dma_err_code, .blk_core_en, .blk_core_write, .blk_core_off,
		.blk_core_width, .blk_io_en, .blk_io_write, .blk_io_off, .blk_io_width, .iop_en,
		.iop_write, .iop_off, .iop_from_dma, .ext_en, .ext_write, .ext_addr);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic chk_code(input imad_pkg::imad_err_e got, input imad_pkg::imad_err_e exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: error code %0d, wanted %0d", $time, got, exp);
		end
	endtask
	task automatic step();
		@(posedge ref_clk);
		#2;
	endtask
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// every range bottom and top, back to back on the program bus
	task automatic t_map();
		logic [31:0] a;
		for (int i = 0; i < 24; i++) begin
			a = i[0] ? HI[i/2] : LO[i/2];
			m.drive(1, a, 1'b0, i/2 == 6 || i/2 == 7);
			step();
			chk(pm_ack, 1'b1);
			chk(blk_core_en, 32'h1 << BK[i/2]);
			chk(blk_core_off[BK[i/2]], a - LO[i/2]);
			chk(blk_core_width[BK[i/2]], WD[i/2]);
		end
		m.idle();
		step();
	endtask
	task automatic t_gap();
		for (int i = 0; i < 9; i++) begin
			m.drive(0, GAP[i], 1'b0, 1'b0);
			step();
			chk(dm_err, 1'b1);
			chk_code(dm_err_code, imad_pkg::IMAD_E_RESERVED);
			chk(blk_core_en, 32'h0);
		end
		m.idle();
		step();
	endtask
	// io space: data bus wins the port, dma comes back alone
	task automatic t_iop();
		m.drive(0, `IMAD_IOP_HI, 1'b0, 1'b0);
		m.drive(2, 32'h10, 1'b1, 1'b0);
		step();
		m.idle();
		chk({iop_en, iop_from_dma, dm_ack, dma_stall}, 32'hB);
		chk(iop_off, 32'h3FFFF);
		step();
		m.drive(2, 32'h10, 1'b1, 1'b0);
		step();
		m.idle();
		chk({iop_en, iop_from_dma, iop_write, dma_ack}, 32'hF);
		chk(iop_off, 32'h10);
		step();
	endtask
	task automatic t_ext();
		m.drive(0, `IMAD_EXT_BASE, 1'b0, 1'b0);
		m.drive(2, 32'h200010, 1'b1, 1'b0);
		step();
		m.idle();
		chk({dm_err, ext_en, ext_write, dma_ack}, 32'hF);
		chk_code(dm_err_code, imad_pkg::IMAD_E_EXTERNAL);
		chk(ext_addr, 32'h200010);
		step();
	endtask
	// mask rom refuses writes; sram ports carry write, offset and view width
	task automatic t_rom();
		m.drive(1, `IMAD_NW_ROM0_LO, 1'b1, 1'b0);
		m.drive(2, `IMAD_SW_ROM1_LO, 1'b1, 1'b0);
		step();
		chk({pm_ack, pm_err, dma_err, blk_core_en, blk_io_en}, 32'h300);
		chk_code(pm_err_code, imad_pkg::IMAD_E_ROMWRITE);
		chk_code(dma_err_code, imad_pkg::IMAD_E_ROMWRITE);
		m.drive(1, 32'h180004, 1'b1, 1'b0);
		m.drive(2, 32'h60003, 1'b0, 1'b0);
		step();
		m.idle();
		chk({pm_ack, dma_ack, blk_core_write[2], blk_io_write[2]}, 32'hE);
		chk_code(pm_err_code, imad_pkg::IMAD_E_NONE);
		chk(blk_core_off[2], 32'h4);
		chk(blk_io_off[2], 32'h3);
		chk({blk_core_width[2], blk_io_width[2]}, 32'h8);
		step();
	endtask
	// all three requesters aim at one block in one cycle
	task automatic t_dual();
		m.drive(0, 32'h80000, 1'b0, 1'b0);
		m.drive(1, 32'h80001, 1'b0, 1'b0);
		m.drive(2, 32'h80002, 1'b1, 1'b0);
		step();
		m.idle();
		chk({dm_ack, pm_stall, dma_ack}, 32'h7);
		chk({blk_core_en, blk_io_en}, 32'h11);
		chk(blk_core_off[0], 32'h0);
		chk(blk_io_off[0], 32'h2);
		step();
	endtask

	initial begin
		#100000;
		n_errors++;
		finish_test();
	end
	initial begin
		repeat (5) @(posedge ref_clk);
		#2;
		chk({dm_ack, pm_ack, dma_ack, blk_core_en, iop_en, ext_en}, 32'h0);
		chk(blk_core_width[0], 32'h1);
		rst = 1'b0;
		step();
		t_map();
		t_gap();
		t_iop();
		t_ext();
		t_rom();
		t_dual();
		finish_test();
	end
endmodule
`default_nettype wire

// *** tb/imad_req_model.sv ***
// requester model standing in for the core buses and the dma engine
`timescale 1ns/1ns
`default_nettype none
`include "imad_defines.svh"
module imad_req_model (
	output logic                    dm_valid,
	output logic [`IMAD_ADDR_W-1:0] dm_addr,
	output logic                    dm_write,
	output logic                    pm_valid,
	output logic [`IMAD_ADDR_W-1:0] pm_addr,
	output logic                    pm_write,
	output logic                    pm_is48,
	output logic                    dma_valid,
	output logic [`IMAD_ADDR_W-1:0] dma_addr,
	output logic                    dma_write
);
	initial begin
		{dm_valid, dm_write, pm_valid, pm_write, pm_is48, dma_valid, dma_write} = 7'h00;
		{dm_addr, pm_addr, dma_addr} = 96'h0;
	end
	// who: 0 data bus, 1 program bus, 2 dma
	task automatic drive(input int who, input logic [31:0] a, input logic w, input logic i48);
		case (who)
			0: begin
				{dm_valid, dm_addr, dm_write} = {1'b1, a, w};
			end
			1: begin
				{pm_valid, pm_addr, pm_write, pm_is48} = {1'b1, a, w, i48};
			end
			default: begin
				// external memory is reached only through this port
				{dma_valid, dma_addr, dma_write} = {1'b1, a, w};
			end
		endcase
	endtask
	// released lines show no stale value
	task automatic idle();
		{dm_valid, pm_valid, dma_valid} = 3'h0;
		{dm_addr, pm_addr, dma_addr} = ~{dm_addr, pm_addr, dma_addr};
	endtask
endmodule
`default_nettype wire
